// ### relay_pkg.sv
// package: register map, source codes and timing constants for the relay controller
package relay_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MAP = 8'h00;
   localparam logic [7:0] ADDR_ZONE1 = 8'h04;
   localparam logic [7:0] ADDR_ZONE2 = 8'h08;
   localparam logic [7:0] ADDR_TMO0 = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_DIST = 8'h20;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int SRC_W = 3;
   localparam int MAP_STRIDE = 4;
   localparam int DIST_W = 16;
   localparam int TMO_W = 15;
   // distance in centimetres
   localparam logic [15:0] ZONE_MAX = 16'h0FA0;
   localparam logic [15:0] ZONE1_RST = 16'h01F4;
   localparam logic [15:0] ZONE2_RST = 16'h03E8;
   // timeout in milliseconds
   localparam logic [14:0] TMO_MAX = 15'h7530;
   localparam logic [14:0] TMO_RST = 15'h03E8;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

   typedef enum logic [2:0] {
      SRC_HEALTH = 3'h0,
      SRC_ZONE1 = 3'h1,
      SRC_ZONE2 = 3'h2,
      SRC_NET = 3'h3,
      SRC_FIELDBUS = 3'h4,
      SRC_PEER = 3'h5
   } relay_src_t;

endpackage : relay_pkg

// ### relay_cmd_if.sv
// interface: remote switching command carried to one relay timer
`timescale 1ns/1ps
interface relay_cmd_if;
   logic cmdValid;
   logic cmdClose;
   logic remoteSel;
   logic [14:0] timeoutMs;
   logic tickMs;
   logic remoteClosed;
   logic expired;

   modport ctrl (output cmdValid, output cmdClose, output remoteSel, output timeoutMs,
      output tickMs, input remoteClosed, input expired);
   modport timer (input cmdValid, input cmdClose, input remoteSel, input timeoutMs,
      input tickMs, output remoteClosed, output expired);
endinterface : relay_cmd_if

// ### relay_timer.sv
// module: remote command latch with watchdog for one relay
`timescale 1ns/1ps
module relay_timer
   import relay_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   relay_cmd_if.timer cmd
);

   logic [14:0] elapsed_reg;
   logic [14:0] elapsed_next;
   logic closed_reg;
   logic closed_next;
   logic expired_reg;
   logic expired_next;
   logic timeUp;

   // zero timeout opens at the next millisecond tick without a command
   assign timeUp = cmd.tickMs && (elapsed_reg >= cmd.timeoutMs);

   always_comb
   begin
      elapsed_next = elapsed_reg;
      closed_next = closed_reg;
      expired_next = expired_reg;
      if (!cmd.remoteSel)
      begin
         // timeout ignored for local sources
         elapsed_next = '0;
         closed_next = 1'b0;
         expired_next = 1'b0;
      end
      else if (cmd.cmdValid)
      begin
         elapsed_next = '0;
         closed_next = cmd.cmdClose;
         expired_next = 1'b0;
      end
      else if (timeUp)
      begin
         closed_next = 1'b0;
         expired_next = 1'b1;
      end
      else if (cmd.tickMs && elapsed_reg != TMO_MAX)
      begin
         elapsed_next = elapsed_reg + 15'h0001;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         elapsed_reg <= '0;
         closed_reg <= 1'b0;
         expired_reg <= 1'b0;
      end
      else
      begin
         elapsed_reg <= elapsed_next;
         closed_reg <= closed_next;
         expired_reg <= expired_next;
      end
   end

   assign cmd.remoteClosed = closed_reg;
   assign cmd.expired = expired_reg;

   property p_cmd_restarts;
      @(posedge sys_clk) disable iff (rst)
      (cmd.remoteSel && cmd.cmdValid) |=> (elapsed_reg == '0);
   endproperty
   a_cmd_restarts: assert property (p_cmd_restarts)
      else $error("command did not restart timeout");

   property p_expire_opens;
      @(posedge sys_clk) disable iff (rst)
      (cmd.remoteSel && !cmd.cmdValid && timeUp) |=> (!closed_reg && expired_reg);
   endproperty
   a_expire_opens: assert property (p_expire_opens)
      else $error("relay not opened at timeout");

   property p_no_early_open;
      @(posedge sys_clk) disable iff (rst)
      (closed_reg && cmd.remoteSel && $stable(cmd.remoteSel) && !cmd.cmdValid && !timeUp)
         |=> closed_reg;
   endproperty
   a_no_early_open: assert property (p_no_early_open)
      else $error("relay opened before timeout");

   property p_local_ignores;
      @(posedge sys_clk) disable iff (rst)
      !cmd.remoteSel |=> (!expired_reg && elapsed_reg == '0);
   endproperty
   a_local_ignores: assert property (p_local_ignores)
      else $error("timeout active for local source");

endmodule : relay_timer

// ### relay_output_controller.sv
// module: four relay outputs with selectable sources and register port
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - four relays, each picks one of six sources
// - health source opens without valid measurement
// - zone one source opens below threshold one
// - zone two source opens below threshold two
// - thresholds 0 to 40 m, defaults 5, 10
// - network source follows customer interface commands
// - fieldbus source follows fieldbus commands
// - peer source follows over-air radar commands
// - per-relay timeout 0..30000 ms, default 1000
// - timeout used only for remote sources
// - open after silent timeout or on an open command; command restarts
module relay_output_controller
   import relay_pkg::*;
#(
   parameter int NUM_RELAYS = 4,
   parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic measValid,
   input wire logic [15:0] measDistCm,
   input wire logic netCmdValid,
   input wire logic [3:0] netCmdClose,
   input wire logic busCmdValid,
   input wire logic [3:0] busCmdClose,
   input wire logic peerCmdValid,
   input wire logic [3:0] peerCmdClose,
   output logic [3:0] relayClosed
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (NUM_RELAYS != 4)
   begin : g_bad_count
      $error("relay_output_controller supports exactly four relays");
   end
   if (CYCLES_PER_MS < 1)
   begin : g_bad_tick
      $error("CYCLES_PER_MS must be at least one");
   end

   localparam int TICK_W = $clog2(CYCLES_PER_MS + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_MS - 1);

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_reg;
   logic tickMs;

   assign tickMs = (tick_reg == TICK_LAST);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         tick_reg <= '0;
      else if (tickMs)
         tick_reg <= '0;
      else
         tick_reg <= tick_reg + TICK_W'(1);
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   relay_src_t map_reg [4];
   logic [15:0] zone1_reg;
   logic [15:0] zone2_reg;
   logic [14:0] tmo_reg [4];
   logic [15:0] wrDist;
   logic [14:0] wrTmo;
   logic [2:0] wrSrc [4];
   logic mapHit;
   logic zone1Hit;
   logic zone2Hit;
   logic distHit;
   logic statusHit;
   logic [3:0] tmoHit;

   assign mapHit = (regAddr == ADDR_MAP);
   assign zone1Hit = (regAddr == ADDR_ZONE1);
   assign zone2Hit = (regAddr == ADDR_ZONE2);
   assign statusHit = (regAddr == ADDR_STATUS);
   assign distHit = (regAddr == ADDR_DIST);
   // out-of-range values saturate to the limit: timeouts over the whole word, distances within bits 15:0 only
   assign wrDist = (regWdata[15:0] > ZONE_MAX) ? ZONE_MAX : regWdata[15:0];
   assign wrTmo = (regWdata[31:15] != '0) ? TMO_MAX :
      ((regWdata[14:0] > TMO_MAX) ? TMO_MAX : regWdata[14:0]);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         zone1_reg <= ZONE1_RST;
         zone2_reg <= ZONE2_RST;
      end
      else if (regWr && zone1Hit)
         zone1_reg <= wrDist;
      else if (regWr && zone2Hit)
         zone2_reg <= wrDist;
   end

   // ----------------------------------------------------------------
   // per-relay source, timer and output
   // ----------------------------------------------------------------
   logic [3:0] remoteSel;
   logic [3:0] localClose;
   logic [3:0] remoteClosed;
   logic [3:0] expired;
   logic [3:0] relayNext;
   logic [3:0] relay_reg;

   for (genvar i = 0; i < 4; i++)
   begin : g_relay
      relay_cmd_if cmdBus ();
      logic [2:0] src;

      assign tmoHit[i] = (regAddr == ADDR_TMO0 + 8'(4 * i));
      assign src = regWdata[MAP_STRIDE*i +: SRC_W];
      // illegal codes fall back to health
      assign wrSrc[i] = (src > 3'(SRC_PEER)) ? 3'(SRC_HEALTH) : src;

      always_ff @(posedge sys_clk)
      begin
         if (rst)
         begin
            map_reg[i] <= SRC_HEALTH;
            tmo_reg[i] <= TMO_RST;
         end
         else
         begin
            if (regWr && mapHit)
               map_reg[i] <= relay_src_t'(wrSrc[i]);
            if (regWr && tmoHit[i])
               tmo_reg[i] <= wrTmo;
         end
      end

      assign remoteSel[i] = (map_reg[i] == SRC_NET) || (map_reg[i] == SRC_FIELDBUS) ||
         (map_reg[i] == SRC_PEER);

      assign cmdBus.remoteSel = remoteSel[i];
      assign cmdBus.timeoutMs = tmo_reg[i];
      assign cmdBus.tickMs = tickMs;
      // only the selected remote source reaches the timer
      assign cmdBus.cmdValid = ((map_reg[i] == SRC_NET) && netCmdValid) ||
         ((map_reg[i] == SRC_FIELDBUS) && busCmdValid) ||
         ((map_reg[i] == SRC_PEER) && peerCmdValid);
      assign cmdBus.cmdClose = (map_reg[i] == SRC_NET) ? netCmdClose[i] :
         ((map_reg[i] == SRC_FIELDBUS) ? busCmdClose[i] : peerCmdClose[i]);

      relay_timer u_timer (
         .sys_clk(sys_clk),
         .rst(rst),
         .cmd(cmdBus)
      );

      assign remoteClosed[i] = cmdBus.remoteClosed;
      assign expired[i] = cmdBus.expired;

      always_comb
      begin
         unique case (map_reg[i])
            SRC_HEALTH: localClose[i] = measValid;
            SRC_ZONE1: localClose[i] = measValid && (measDistCm >= zone1_reg);
            SRC_ZONE2: localClose[i] = measValid && (measDistCm >= zone2_reg);
            default: localClose[i] = 1'b0;
         endcase
      end

      assign relayNext[i] = remoteSel[i] ? remoteClosed[i] : localClose[i];
   end

   // ----------------------------------------------------------------
   // relay outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         relay_reg <= '0;
      else
         relay_reg <= relayNext;
   end

   assign relayClosed = relay_reg;

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   logic [31:0] mapWord;
   logic [31:0] tmoWord;
   logic [31:0] rdMux;
   logic [31:0] rdata_reg;

   assign mapWord = {16'h0000, 1'b0, map_reg[3], 1'b0, map_reg[2], 1'b0, map_reg[1],
      1'b0, map_reg[0]};
   assign tmoWord = tmoHit[0] ? {17'h00000, tmo_reg[0]} :
      tmoHit[1] ? {17'h00000, tmo_reg[1]} :
      tmoHit[2] ? {17'h00000, tmo_reg[2]} :
      tmoHit[3] ? {17'h00000, tmo_reg[3]} : 32'h00000000;
   // unmapped addresses read zero
   assign rdMux = mapHit ? mapWord :
      zone1Hit ? {16'h0000, zone1_reg} :
      zone2Hit ? {16'h0000, zone2_reg} :
      statusHit ? {20'h00000, expired, remoteClosed, relay_reg} :
      distHit ? {15'h0000, measValid, measDistCm} : tmoWord;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rdata_reg <= '0;
      else if (regRd)
         rdata_reg <= rdMux;
      else
         rdata_reg <= '0;
   end

   assign regRdata = rdata_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_health_open;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[0] == SRC_HEALTH && !measValid) |=> !relayClosed[0];
   endproperty
   a_health_open: assert property (p_health_open)
      else $error("health relay closed without valid measurement");

   property p_zone1_open;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[0] == SRC_ZONE1 && measDistCm < zone1_reg) |=> !relayClosed[0];
   endproperty
   a_zone1_open: assert property (p_zone1_open)
      else $error("zone one relay closed below threshold");

   property p_zone2_follow;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[1] == SRC_ZONE2) |=>
         (relayClosed[1] == ($past(measValid) && $past(measDistCm) >= $past(zone2_reg)));
   endproperty
   a_zone2_follow: assert property (p_zone2_follow)
      else $error("zone two relay does not follow comparison");

   property p_zone_limit;
      @(posedge sys_clk) disable iff (rst)
      (zone1_reg <= ZONE_MAX) && (zone2_reg <= ZONE_MAX) && (tmo_reg[3] <= TMO_MAX);
   endproperty
   a_zone_limit: assert property (p_zone_limit)
      else $error("setting above allowed range");

   property p_net_follow;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[0] == SRC_NET && netCmdValid) ##1 (map_reg[0] == SRC_NET) |=>
         (relayClosed[0] == $past(netCmdClose[0], 2));
   endproperty
   a_net_follow: assert property (p_net_follow)
      else $error("network command not applied in two cycles");

   property p_reset_open;
      @(posedge sys_clk) rst |=> (relayClosed == 4'h0 && regRdata == 32'h00000000);
   endproperty
   a_reset_open: assert property (p_reset_open)
      else $error("relay closed after reset");

   property p_zone1_close;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[0] == SRC_ZONE1 && measValid && measDistCm >= zone1_reg) |=> relayClosed[0];
   endproperty
   a_zone1_close: assert property (p_zone1_close)
      else $error("zone one relay open at or above threshold");

   property p_health_close;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[3] == SRC_HEALTH && measValid) |=> relayClosed[3];
   endproperty
   a_health_close: assert property (p_health_close)
      else $error("health relay open with valid measurement");

   property p_bus_follow;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[1] == SRC_FIELDBUS && busCmdValid) ##1 (map_reg[1] == SRC_FIELDBUS) |=>
         (relayClosed[1] == $past(busCmdClose[1], 2));
   endproperty
   a_bus_follow: assert property (p_bus_follow)
      else $error("fieldbus command not applied in two cycles");

   property p_peer_follow;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[2] == SRC_PEER && peerCmdValid) ##1 (map_reg[2] == SRC_PEER) |=>
         (relayClosed[2] == $past(peerCmdClose[2], 2));
   endproperty
   a_peer_follow: assert property (p_peer_follow)
      else $error("peer command not applied in two cycles");

   property p_remote_open;
      @(posedge sys_clk) disable iff (rst)
      (remoteSel[0] && !remoteClosed[0]) |=> !relayClosed[0];
   endproperty
   a_remote_open: assert property (p_remote_open)
      else $error("remote relay closed without latched close");

   property p_map_legal;
      @(posedge sys_clk) disable iff (rst)
      (map_reg[0] <= SRC_PEER) && (map_reg[1] <= SRC_PEER) && (map_reg[2] <= SRC_PEER) &&
         (map_reg[3] <= SRC_PEER);
   endproperty
   a_map_legal: assert property (p_map_legal)
      else $error("illegal source code stored");

   property p_tmo_limit;
      @(posedge sys_clk) disable iff (rst)
      (tmo_reg[0] <= TMO_MAX) && (tmo_reg[1] <= TMO_MAX) && (tmo_reg[2] <= TMO_MAX);
   endproperty
   a_tmo_limit: assert property (p_tmo_limit)
      else $error("timeout above allowed range");

   property p_reset_defaults;
      @(posedge sys_clk) rst |=>
         (zone1_reg == ZONE1_RST && zone2_reg == ZONE2_RST && tmo_reg[0] == TMO_RST);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("settings not at defaults after reset");

   property p_map_reset;
      @(posedge sys_clk) rst |=> (map_reg[0] == SRC_HEALTH && map_reg[1] == SRC_HEALTH &&
         map_reg[2] == SRC_HEALTH && map_reg[3] == SRC_HEALTH);
   endproperty
   a_map_reset: assert property (p_map_reset)
      else $error("source map not health after reset");

endmodule : relay_output_controller

// ### cmd_sender.sv
// remote command sources: customer network, fieldbus and peer radar
`timescale 1ns/1ps
module cmd_sender
(
   input wire logic sys_clk,
   output logic netCmdValid,
   output logic [3:0] netCmdClose,
   output logic busCmdValid,
   output logic [3:0] busCmdClose,
   output logic peerCmdValid,
   output logic [3:0] peerCmdClose
);
   initial
   begin
      netCmdValid = 1'b0;
      busCmdValid = 1'b0;
      peerCmdValid = 1'b0;
      netCmdClose = 4'h0;
      busCmdClose = 4'h0;
      peerCmdClose = 4'h0;
   end

   // ----------------------------------------------------------------
   // one-cycle command pulse
   // ----------------------------------------------------------------
   // caller repeats commands sooner than the timeout to hold a relay
   task automatic send(input logic [1:0] src, input logic [3:0] close);
      begin
         @(posedge sys_clk);
         netCmdValid <= (src == 2'h0);
         busCmdValid <= (src == 2'h1);
         peerCmdValid <= (src == 2'h2);
         netCmdClose <= close;
         busCmdClose <= close;
         peerCmdClose <= close;
         @(posedge sys_clk);
         netCmdValid <= 1'b0;
         busCmdValid <= 1'b0;
         peerCmdValid <= 1'b0;
         // stale data must never look like a fresh command
         netCmdClose <= ~close;
         busCmdClose <= ~close;
         peerCmdClose <= ~close;
      end
   endtask : send
endmodule : cmd_sender

// ### tb_top.sv
// self-checking bench for the relay output controller
`timescale 1ns/1ps
module tb_top;
   import relay_pkg::*;
   // short ms tick keeps timeout runs brief
   localparam int CPM = 4;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic measValid = 1'b0;
   logic [15:0] measDistCm = 16'h0000;
   logic netCmdValid, busCmdValid, peerCmdValid;
   logic [3:0] netCmdClose, busCmdClose, peerCmdClose;
   logic [3:0] relayClosed;
   int errors = 0;
   int checks = 0;
   int cycles = 0;

   always #20 sys_clk = ~sys_clk;

   cmd_sender partner (.sys_clk(sys_clk), .netCmdValid(netCmdValid),
      .netCmdClose(netCmdClose), .busCmdValid(busCmdValid), .busCmdClose(busCmdClose),
      .peerCmdValid(peerCmdValid), .peerCmdClose(peerCmdClose));

   relay_output_controller #(.NUM_RELAYS(4), .CYCLES_PER_MS(CPM)) uut (.sys_clk(sys_clk),
      .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .measValid(measValid), .measDistCm(measDistCm),
      .netCmdValid(netCmdValid), .netCmdClose(netCmdClose), .busCmdValid(busCmdValid),
      .busCmdClose(busCmdClose), .peerCmdValid(peerCmdValid),
      .peerCmdClose(peerCmdClose), .relayClosed(relayClosed));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic stop_test();
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask : stop_test

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles >= 6000)
      begin
         errors = errors + 1;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            errors = errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge sys_clk);
         regWr <= 1'b1;
         regAddr <= a;
         regWdata <= d;
         @(posedge sys_clk);
         regWr <= 1'b0;
      end
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      begin
         @(posedge sys_clk);
         regRd <= 1'b1;
         regAddr <= a;
         @(posedge sys_clk);
         regRd <= 1'b0;
         #1;
         chk(regRdata, exp);
      end
   endtask : rdc

   task automatic waitc(input int n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask : waitc

   task automatic rly(input logic [3:0] exp);
      begin
         chk({28'h0, relayClosed}, {28'h0, exp});
      end
   endtask : rly

   task automatic meas(input logic v, input logic [15:0] d);
      begin
         @(posedge sys_clk);
         measValid <= v;
         measDistCm <= d;
         waitc(3);
      end
   endtask : meas

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      waitc(1);
      rly(4'h0);
      rdc(ADDR_MAP, 32'h0);
      rdc(ADDR_ZONE1, {16'h0, ZONE1_RST});
      rdc(ADDR_ZONE2, {16'h0, ZONE2_RST});
      rdc(ADDR_TMO0 + 8'h0C, {17'h0, TMO_RST});
      rdc(8'h40, 32'h0);
      // codes 6 and 7 fall back to health
      wr(ADDR_MAP, 32'h0000_7676);
      rdc(ADDR_MAP, 32'h0);
      wr(ADDR_ZONE1, 32'h0000_FFFF);
      rdc(ADDR_ZONE1, {16'h0, ZONE_MAX});
      wr(ADDR_TMO0, 32'hFFFF_FFFF);
      rdc(ADDR_TMO0, {17'h0, TMO_MAX});
      wr(ADDR_ZONE1, 32'h0000_01F4);
      // health source on all relays
      meas(1'b1, 16'h0258);
      rly(4'hF);
      rdc(ADDR_DIST, 32'h0001_0258);
      meas(1'b0, 16'h0258);
      rly(4'h0);
      // relay0 zone one, relay1 zone two
      wr(ADDR_MAP, 32'h0000_0021);
      meas(1'b1, 16'h02BC);
      rly(4'hD);
      meas(1'b1, 16'h01F3);
      rly(4'hC);
      meas(1'b1, 16'h03E8);
      rly(4'hF);
      // relay0 network, relay1 fieldbus, relay2 peer, relay3 health
      wr(ADDR_MAP, 32'h0000_0543);
      wr(ADDR_TMO0, 32'h0000_0003);
      wr(ADDR_TMO0 + 8'h04, 32'h0000_0000);
      wr(ADDR_TMO0 + 8'h0C, 32'h0000_0000);
      rdc(ADDR_MAP, 32'h0000_0543);
      waitc(2);
      rly(4'h8);
      partner.send(2'h2, 4'hF);
      waitc(2);
      rly(4'hC);
      partner.send(2'h1, 4'hF);
      waitc(1);
      rly(4'hE);
      waitc(7);
      rly(4'hC);
      partner.send(2'h0, 4'hF);
      waitc(9);
      rly(4'hD);
      partner.send(2'h0, 4'hF);
      waitc(9);
      rly(4'hD);
      waitc(8);
      rly(4'hC);
      rdc(ADDR_STATUS, 32'h0000_034C);
      partner.send(2'h0, 4'hF);
      partner.send(2'h0, 4'h0);
      waitc(2);
      rly(4'hC);
      waitc(20);
      rly(4'hC);
      wr(ADDR_MAP, 32'h0000_0000);
      waitc(3);
      rly(4'hF);
      // reset in mid-run opens every relay and restores defaults
      @(posedge sys_clk);
      rst <= 1'b1;
      waitc(2);
      rly(4'h0);
      @(posedge sys_clk);
      rst <= 1'b0;
      rdc(ADDR_TMO0, {17'h0, TMO_RST});
      stop_test();
   end
endmodule : tb_top
